/* File: pkg/adc_pkg.sv */
// Shared constants for the converter sequencing control block
package adc_pkg;
   // Register indexes; byte address is four times the index
   localparam int ADDR_W = 12;
   localparam logic [9:0] IDX_MODE = 10'h0c4;
   localparam logic [9:0] IDX_RESULT = 10'h0c5;
   localparam logic [9:0] IDX_START = 10'h0c6;
   localparam logic [9:0] IDX_IRQ_STAT = 10'h0c7;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h0c8;
   // Mode register fields
   localparam int MODE_CKS_BIT = 7;
   localparam int MODE_EXT_TRIGGER_ENABLE_BIT = 6;
   localparam int MODE_CHAN_LSB = 0;
   localparam logic [7:0] MODE_RSVD_ONES = 8'h30;
   localparam logic [3:0] CHAN_RESET = 4'h0;
   localparam logic [3:0] CHAN_FIRST_CODE = 4'h4;
   // Start/status register fields
   localparam int FLAG_BIT = 7;
   localparam logic [7:0] START_RSVD_ONES = 8'h7f;
   // Interrupt bits
   localparam int IRQ_DONE_BIT = 0;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   // Conversion periods in system clock cycles
   localparam logic [5:0] PERIOD_SLOW = 6'h3e;
   localparam logic [5:0] PERIOD_FAST = 6'h1f;
   // Shortest legal conversion time and its cycle count at the core clock
   localparam int CLK_PERIOD_NS = 20;
   localparam int CONV_MIN_TIME_NS = 12400;
   localparam int CONV_MIN_CYCLES =
      (CONV_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register index from a byte address
   function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
      return addr[ADDR_W-1:2];
   endfunction : reg_index
endpackage : adc_pkg

/* File: pkg/conv_if.sv */
// Control and result signals between register logic and conversion engine
`timescale 1ns/1ps
interface conv_if;
   logic start;
   logic stop;
   logic fast;
   logic [7:0] sample;
   logic busy;
   logic done;
   logic [7:0] result;
   modport ctrl (output start, output stop, output fast, output sample,
                 input busy, input done, input result);
   modport engine (input start, input stop, input fast, input sample,
                   output busy, output done, output result);
endinterface : conv_if

/* File: rtl/conv_engine.sv */
// Conversion timing engine: counts the period and captures the result
`timescale 1ns/1ps
module conv_engine (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control side
   conv_if.engine cv
);
   typedef enum logic {ST_IDLE, ST_CONV} eng_state_t;
   eng_state_t state, next_state;
   logic [5:0] cnt, next_cnt;
   logic [5:0] last, next_last;
   logic [7:0] result, next_result;
   logic done_c;

   // Next-state logic; a stop wins over completion in the same cycle
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_last = last;
      next_result = result;
      done_c = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (cv.start) begin
               next_state = ST_CONV;
               next_cnt = 6'h00;
               next_last = (cv.fast ? adc_pkg::PERIOD_FAST
                                    : adc_pkg::PERIOD_SLOW) - 6'h01;
            end
         end
         ST_CONV: begin
            if (cv.stop) begin
               next_state = ST_IDLE;
            end else if (cnt == last) begin
               done_c = 1'b1;
               next_state = ST_IDLE;
               next_result = cv.sample;
            end else begin
               next_cnt = cnt + 6'h01;
            end
         end
      endcase
   end

   // Control state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         cnt <= 6'h00;
         last <= 6'h00;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         last <= next_last;
      end
   end

   // Result has no reset: content is unknown until the first conversion
   always_ff @(posedge aclk) begin
      result <= next_result;
   end

   assign cv.busy = (state == ST_CONV);
   assign cv.done = done_c;
   assign cv.result = result;

   // Helper: busy cycle count and period chosen at start
   logic [6:0] run_len;
   logic fast_at_start;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_len <= 7'h00;
         fast_at_start <= 1'b0;
      end else begin
         run_len <= cv.busy ? run_len + 7'h01 : 7'h00;
         if (!cv.busy && cv.start) begin
            fast_at_start <= cv.fast;
         end
      end
   end

   period_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cv.done |-> run_len == {1'b0, (fast_at_start ? adc_pkg::PERIOD_FAST
                                     : adc_pkg::PERIOD_SLOW) - 6'h01})
      else $error("conversion period length wrong");

   sequence finish_s;
      cv.done ##1 !cv.busy;
   endsequence
   result_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cv.done |-> finish_s ##0 cv.result == $past(cv.sample))
      else $error("result not loaded with flag clear");
endmodule : conv_engine

/* File: rtl/adc_sequencing_control.sv */
// Converter sequencing control: AXI4-Lite registers, trigger and mux select
// Overview of operation
// - Channel codes with upper two bits zero select no input; 4..15 pick 0..11.
// - With trigger enable clear the trigger pin is ignored; only software starts.
// - With trigger enable set any edge on the trigger pin starts a conversion while idle; edges while busy are dropped.
// - Clock select clear gives a 62-cycle period, set gives 31 cycles.
// - Writing flag 1 starts, 0 stops; reading 1 means busy, 0 means done.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adc_sequencing_control (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [adc_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [adc_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Analog side
   input wire logic ext_conv_trigger_pin,
   input wire logic [7:0] conv_sample,
   output logic analog_mux_en,
   output logic [3:0] analog_chan,
   // Interrupt
   output logic irq
);
   conv_if cv ();

   conv_engine u_engine (
      .aclk(aclk),
      .aresetn(aresetn),
      .cv(cv.engine)
   );

   // Register state
   logic [3:0] chan_sel, next_chan_sel;
   logic ext_trigger_enable, next_ext_trigger_enable;
   logic conv_clock_select, next_conv_clock_select;
   logic [7:0] irq_stat, next_irq_stat;
   logic [7:0] irq_mask, next_irq_mask;
   logic next_mux_en;
   logic [3:0] next_analog_chan;
   // Bus state
   logic aw_held, next_aw_held;
   logic [9:0] aw_idx, next_aw_idx;
   logic w_held, next_w_held;
   logic [7:0] w_byte, next_w_byte;
   logic w_lane0, next_w_lane0;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   // Synchronisers
   logic trig_s1, trig_s2, trig_s3;
   logic [7:0] samp_s1, samp_s2;
   logic wr_fire, sw_start, sw_stop, trig_start;

   // Pins pass two flops; the third trigger flop feeds the edge detector
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
         samp_s1 <= 8'h00;
         samp_s2 <= 8'h00;
      end else begin
         trig_s1 <= ext_conv_trigger_pin;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
         samp_s1 <= conv_sample;
         samp_s2 <= samp_s1;
      end
   end

   // Both edges start; a disabled trigger never reaches the engine
   assign trig_start = ext_trigger_enable && (trig_s2 != trig_s3);

   assign awready = !aw_held;
   assign wready = !w_held;
   assign arready = !rvalid;
   assign wr_fire = aw_held && w_held && !bvalid;
   assign sw_start = wr_fire && w_lane0 && aw_idx == adc_pkg::IDX_START
                     && w_byte[adc_pkg::FLAG_BIT];
   assign sw_stop = wr_fire && w_lane0 && aw_idx == adc_pkg::IDX_START
                    && !w_byte[adc_pkg::FLAG_BIT];
   // A start while busy is dropped by the engine, so no restart glitch
   assign cv.start = sw_start || trig_start;
   assign cv.stop = sw_stop;
   assign cv.fast = conv_clock_select;
   assign cv.sample = samp_s2;
   assign irq = |(irq_stat & irq_mask);

   // Register next values; a done event beats a same-cycle clear
   always_comb begin
      next_chan_sel = chan_sel;
      next_ext_trigger_enable = ext_trigger_enable;
      next_conv_clock_select = conv_clock_select;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (wr_fire && w_lane0) begin
         unique case (aw_idx)
            adc_pkg::IDX_MODE: begin
               next_chan_sel = w_byte[adc_pkg::MODE_CHAN_LSB +: 4];
               next_ext_trigger_enable = w_byte[adc_pkg::MODE_EXT_TRIGGER_ENABLE_BIT];
               next_conv_clock_select = w_byte[adc_pkg::MODE_CKS_BIT];
            end
            adc_pkg::IDX_IRQ_STAT: next_irq_stat = irq_stat & ~w_byte;
            adc_pkg::IDX_IRQ_MASK: next_irq_mask = w_byte;
            default: ;
         endcase
      end
      if (cv.done) begin
         next_irq_stat[adc_pkg::IRQ_DONE_BIT] = 1'b1;
      end
      // Codes below the first input leave the mux open
      next_mux_en = next_chan_sel[3:2] != 2'h0;
      next_analog_chan = next_mux_en
         ? next_chan_sel - adc_pkg::CHAN_FIRST_CODE : 4'h0;
   end

   // Bus next values; reads have no side effects
   always_comb begin
      next_aw_held = aw_held;
      next_aw_idx = aw_idx;
      next_w_held = w_held;
      next_w_byte = w_byte;
      next_w_lane0 = w_lane0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_idx = adc_pkg::reg_index(awaddr);
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_byte = wdata[7:0];
         next_w_lane0 = wstrb[0];
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = (aw_idx >= adc_pkg::IDX_MODE
                       && aw_idx <= adc_pkg::IDX_IRQ_MASK)
                      ? adc_pkg::RESP_OKAY : adc_pkg::RESP_SLVERR;
      end
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = adc_pkg::RESP_OKAY;
         next_rdata = 32'h0000_0000;
         unique case (adc_pkg::reg_index(araddr))
            adc_pkg::IDX_MODE: next_rdata[7:0] = adc_pkg::MODE_RSVD_ONES
               | {conv_clock_select, ext_trigger_enable, 2'h0, chan_sel};
            adc_pkg::IDX_RESULT: next_rdata[7:0] = cv.result;
            adc_pkg::IDX_START: next_rdata[7:0] = adc_pkg::START_RSVD_ONES
               | {cv.busy, 7'h00};
            adc_pkg::IDX_IRQ_STAT: next_rdata[7:0] = irq_stat;
            adc_pkg::IDX_IRQ_MASK: next_rdata[7:0] = irq_mask;
            default: next_rresp = adc_pkg::RESP_SLVERR;
         endcase
      end
   end

   // Registers for both groups
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_sel <= adc_pkg::CHAN_RESET;
         ext_trigger_enable <= 1'b0;
         conv_clock_select <= 1'b0;
         irq_stat <= adc_pkg::IRQ_RESET;
         irq_mask <= adc_pkg::IRQ_RESET;
         analog_mux_en <= 1'b0;
         analog_chan <= 4'h0;
         aw_held <= 1'b0;
         aw_idx <= 10'h000;
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= adc_pkg::RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= adc_pkg::RESP_OKAY;
      end else begin
         chan_sel <= next_chan_sel;
         ext_trigger_enable <= next_ext_trigger_enable;
         conv_clock_select <= next_conv_clock_select;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         analog_mux_en <= next_mux_en;
         analog_chan <= next_analog_chan;
         aw_held <= next_aw_held;
         aw_idx <= next_aw_idx;
         w_held <= next_w_held;
         w_byte <= next_w_byte;
         w_lane0 <= next_w_lane0;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   chan_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      analog_mux_en == (chan_sel[3:2] != 2'h0)
      && (!analog_mux_en
          || analog_chan + adc_pkg::CHAN_FIRST_CODE == chan_sel))
      else $error("channel select mapping wrong");

   trig_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ext_trigger_enable && !sw_start && !cv.busy |=> !cv.busy)
      else $error("conversion began without software start");

   sequence pin_edge_s;
      ext_trigger_enable && $changed(trig_s2) && !cv.busy;
   endsequence
   trig_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pin_edge_s |=> cv.busy)
      else $error("trigger edge did not start conversion");

   sequence sw_go_s;
      sw_start && !cv.busy;
   endsequence
   sequence sw_halt_s;
      sw_stop && cv.busy;
   endsequence
   flag_ctrl_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (sw_go_s |=> cv.busy) and (sw_halt_s |=> !cv.busy))
      else $error("flag write had wrong effect");

   flag_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready
      && adc_pkg::reg_index(araddr) == adc_pkg::IDX_START
      |=> rvalid && rdata[7] == $past(cv.busy))
      else $error("flag readback wrong");
endmodule : adc_sequencing_control

/* File: test/analog_partner.sv */
// Far-side model: analog inputs for each channel and the trigger pin
`timescale 1ns/1ps
module analog_partner (
   // Clock
   input wire logic aclk,
   // Mux select from the block
   input wire logic analog_mux_en,
   input wire logic [3:0] analog_chan,
   // Trigger request from the bench
   input wire logic trig_level,
   // Pins into the block
   output logic ext_conv_trigger_pin,
   output logic [7:0] conv_sample
);
   // Each input reads back its own number, so a wrong mux shows at once
   assign conv_sample = analog_mux_en ? {4'h4, analog_chan} : 8'hc3;
   // Trigger pin follows the bench one cycle later; the bench holds it
   // low through reset, so no edge is seen while reset releases
   always @(posedge aclk) begin
      ext_conv_trigger_pin <= trig_level;
   end
endmodule : analog_partner

/* File: test/tb_adc_sequencing_control.sv */
// Self-checking bench for the converter sequencing control block
`timescale 1ns/1ps
module tb_adc_sequencing_control;
   // Clock, reset and bookkeeping
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   // Bus and pin nets
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, trig_level = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic analog_mux_en, ext_conv_trigger_pin;
   logic [1:0] bresp, rresp;
   logic [3:0] analog_chan;
   logic [7:0] conv_sample;
   // Byte addresses of the registers
   localparam logic [11:0] A_MODE = {adc_pkg::IDX_MODE, 2'h0};
   localparam logic [11:0] A_RES = {adc_pkg::IDX_RESULT, 2'h0};
   localparam logic [11:0] A_START = {adc_pkg::IDX_START, 2'h0};
   localparam logic [11:0] A_STAT = {adc_pkg::IDX_IRQ_STAT, 2'h0};
   localparam logic [11:0] A_MASK = {adc_pkg::IDX_IRQ_MASK, 2'h0};

   adc_sequencing_control u_adc_sequencing_control (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .ext_conv_trigger_pin(ext_conv_trigger_pin),
      .conv_sample(conv_sample), .analog_mux_en(analog_mux_en),
      .analog_chan(analog_chan), .irq(irq));

   analog_partner u_analog_partner (
      .aclk(aclk), .analog_mux_en(analog_mux_en),
      .analog_chan(analog_chan), .trig_level(trig_level),
      .ext_conv_trigger_pin(ext_conv_trigger_pin),
      .conv_sample(conv_sample));

   // Free-running bench clock
   initial begin
      forever #10 aclk = ~aclk;
   end

   // Verdict and end of run
   task automatic stop_test();
      if (fail_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      logic aw_d, w_d;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_d = 1'b0;
      w_d = 1'b0;
      do begin
         @(posedge aclk);
         if (!aw_d && awready === 1'b1) begin
            aw_d = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_d && wready === 1'b1) begin
            w_d = 1'b1;
            wvalid <= 1'b0;
         end
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic ar_d;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ar_d = 1'b0;
      do begin
         @(posedge aclk);
         if (!ar_d && arready === 1'b1) begin
            ar_d = 1'b1;
            arvalid <= 1'b0;
         end
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask : rd

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                         input string what);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(what, exp, d);
      chk("rresp", {30'h0, adc_pkg::RESP_OKAY}, {30'h0, r});
   endtask : rd_chk

   // Cycles from the start write's answer until the interrupt rises
   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(posedge aclk);
         n++;
      end
   endtask : wait_irq

   // Bounded poll of the status flag until the conversion ends
   task automatic poll_idle();
      logic [31:0] d;
      logic [1:0] r;
      int k;
      k = 0;
      do begin
         rd(A_START, d, r);
         k++;
      end while (d[7] !== 1'b0 && k < 60);
      chk("busy flag", 32'h0, {31'h0, d[7]});
   endtask : poll_idle

   // Hang guard; the whole run needs under a thousand cycles
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int n;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      chk("irq", 32'h0, {31'h0, irq});
      rd_chk(A_MODE, 32'h30, "mode reset");
      rd_chk(A_START, 32'h7f, "start reset");
      rd_chk(A_STAT, 32'h0, "status reset");
      rd(12'h000, d, r);
      chk("unmapped", {30'h0, adc_pkg::RESP_SLVERR}, {30'h0, r});
      chk("unmapped data", 32'h0, d);
      wr(12'h000, 8'h00, adc_pkg::RESP_SLVERR);
      // Every channel code against mux enable and input number
      for (int c = 0; c < 16; c++) begin
         wr(A_MODE, c[7:0], adc_pkg::RESP_OKAY);
         chk("mux en", {31'h0, c >= 4}, {31'h0, analog_mux_en});
         chk("chan", (c >= 4) ? c - 4 : 0, {28'h0, analog_chan});
         rd_chk(A_MODE, 32'h30 | c, "mode");
      end
      // Software start at both periods, interrupt enabled
      wr(A_MASK, 8'h01, adc_pkg::RESP_OKAY);
      // Slow period, 62 cycles, is still short of the 620-cycle minimum conversion time
      wr(A_MODE, 8'h06, adc_pkg::RESP_OKAY);
      wr(A_START, 8'h80, adc_pkg::RESP_OKAY);
      wait_irq(n);
      chk("slow period", adc_pkg::PERIOD_SLOW, n);
      rd_chk(A_RES, 32'h42, "result");
      rd_chk(A_START, 32'h7f, "done flag");
      wr(A_STAT, 8'h01, adc_pkg::RESP_OKAY);
      chk("irq clear", 32'h0, {31'h0, irq});
      wr(A_MODE, 8'h8f, adc_pkg::RESP_OKAY);
      wr(A_START, 8'h80, adc_pkg::RESP_OKAY);
      wait_irq(n);
      chk("fast period", adc_pkg::PERIOD_FAST, n);
      rd_chk(A_RES, 32'h4b, "result");
      wr(A_STAT, 8'h01, adc_pkg::RESP_OKAY);
      // Result register ignores writes
      wr(A_RES, 8'h00, adc_pkg::RESP_OKAY);
      rd_chk(A_RES, 32'h4b, "result ro");
      // Stop in mid-conversion: no result, no interrupt
      wr(A_MODE, 8'h04, adc_pkg::RESP_OKAY);
      wr(A_START, 8'h80, adc_pkg::RESP_OKAY);
      rd_chk(A_START, 32'hff, "busy flag");
      wr(A_START, 8'h00, adc_pkg::RESP_OKAY);
      rd_chk(A_START, 32'h7f, "stopped");
      repeat (70) @(posedge aclk);
      chk("irq stop", 32'h0, {31'h0, irq});
      rd_chk(A_RES, 32'h4b, "result kept");
      // Trigger edges ignored while disabled
      wr(A_MODE, 8'h05, adc_pkg::RESP_OKAY);
      for (int e = 0; e < 2; e++) begin
         trig_level <= ~trig_level;
         repeat (6) @(posedge aclk);
         rd_chk(A_START, 32'h7f, "no trigger");
      end
      // Rising then falling edge each start one, interrupt masked
      wr(A_MASK, 8'h00, adc_pkg::RESP_OKAY);
      wr(A_MODE, 8'h45, adc_pkg::RESP_OKAY);
      for (int e = 0; e < 2; e++) begin
         trig_level <= ~trig_level;
         repeat (6) @(posedge aclk);
         rd_chk(A_START, 32'hff, "trigger start");
         poll_idle();
         rd_chk(A_RES, 32'h41, "trig result");
      end
      chk("irq masked", 32'h0, {31'h0, irq});
      rd_chk(A_STAT, 32'h1, "status sticky");
      wr(A_MASK, 8'h01, adc_pkg::RESP_OKAY);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(A_STAT, 8'h01, adc_pkg::RESP_OKAY);
      chk("irq cleared", 32'h0, {31'h0, irq});
      stop_test();
   end
endmodule : tb_adc_sequencing_control
